// ===== rtl/spl_pkg.sv
package spl_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // control register layout
   localparam int unsigned CTRL_ENABLE_BIT = 0; // self-program enable
   localparam int unsigned CTRL_LOCK_SEL_BIT = 3; // lock_select_bit
   localparam logic [6:0] CTRL_LOCK_CMD = 7'h09; // low seven bits of X0001001
   localparam logic [7:0] CTRL_LOCK_BYTE = 8'h09; // host drives X as zero
   ////////////////////////////////////////////////////////////////////////////
   // command windows, counted in cycles after the control write
   localparam logic [2:0] LOAD_WIN = 3'h3;
   localparam logic [2:0] STORE_WIN = 3'h4;
   ////////////////////////////////////////////////////////////////////////////
   // pointer values and nonvolatile byte layout
   localparam logic [15:0] ZPTR_FUSE_LOW = 16'h0000;
   localparam logic [15:0] ZPTR_LOCK = 16'h0001;
   localparam logic [15:0] ZPTR_FUSE_HIGH = 16'h0003;
   localparam logic [7:0] BOOT_LOCK_MASK = 8'h3c; // boot lock bits 5..2
   localparam logic [7:0] R0_FILL_MASK = 8'hc3; // bits 7,6,1,0 driven high
   localparam logic [7:0] NV_ERASED = 8'hff; // all bits unprogrammed
   ////////////////////////////////////////////////////////////////////////////
   // write timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned T_WRITE_MIN_NS = 3_700_000;
   localparam int unsigned T_WRITE_MAX_NS = 4_500_000;
   localparam int unsigned WRITE_MIN_CYC = (T_WRITE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WRITE_MAX_CYC = T_WRITE_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned WRITE_CNT_W = 17;
   ////////////////////////////////////////////////////////////////////////////
   // host register map (byte addresses on the 3-bit port)
   localparam logic [2:0] HREG_CMD = 3'h0;
   localparam logic [2:0] HREG_ZPTR_LO = 3'h1;
   localparam logic [2:0] HREG_ZPTR_HI = 3'h2;
   localparam logic [2:0] HREG_DATA = 3'h3;
   localparam logic [2:0] HREG_RESULT = 3'h4;
   localparam logic [2:0] HREG_STATUS = 3'h5;
   localparam logic [2:0] HREG_INT_STAT = 3'h6;
   localparam logic [2:0] HREG_INT_MASK = 3'h7;
   localparam int unsigned CMD_WRITE_BIT = 0;
   localparam int unsigned CMD_READ_BIT = 1;
   localparam int unsigned CMD_IRQ_EN_BIT = 2;
   localparam int unsigned INT_READ_DONE = 0;
   localparam int unsigned INT_WRITE_DONE = 1;
   localparam int unsigned INT_REFUSED = 2;
   localparam logic [7:0] HOST_RST_DATA = 8'hff;
   localparam logic [15:0] HOST_RST_ZPTR = 16'h0001;

   // host sequencer states
   typedef enum logic [4:0] {
      SPL_IDLE = 5'b00001,
      SPL_POLL = 5'b00010,
      SPL_CTRL = 5'b00100,
      SPL_ISSUE = 5'b01000,
      SPL_WAIT = 5'b10000
   } spl_state_e;
endpackage : spl_pkg

// ===== rtl/spl_if.sv
interface spl_if;
   // cpu side requests
   logic ctrl_wr; // one-cycle write of the control register
   logic [7:0] ctrl_wdata;
   logic store_req; // one-cycle store-program instruction
   logic load_req; // one-cycle load-program instruction
   logic [15:0] zptr;
   logic [7:0] r0_data; // cpu_register_zero contents
   logic irq_en; // self-programming interrupt enable
   // controller answers
   logic [7:0] ctrl_rdata;
   logic load_valid;
   logic [7:0] load_data;
   logic eeprom_busy; // eeprom_write_busy as seen by the cpu
   logic spm_irq;

   modport dev_mp (
      input ctrl_wr, ctrl_wdata, store_req, load_req, zptr, r0_data, irq_en,
      output ctrl_rdata, load_valid, load_data, eeprom_busy, spm_irq
   );
   modport host_mp (
      output ctrl_wr, ctrl_wdata, store_req, load_req, zptr, r0_data, irq_en,
      input ctrl_rdata, load_valid, load_data, eeprom_busy, spm_irq
   );
endinterface : spl_if

// ===== rtl/spl_nv_timer.sv
module spl_nv_timer
   import spl_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = WRITE_MIN_CYC
) (
   // clock and power-on reset only
   input wire logic clock,
   input wire logic por_rst,
   // control
   input wire logic start,
   output logic busy,
   output logic done
);
   localparam logic [WRITE_CNT_W-1:0] LAST = WRITE_CNT_W'(WRITE_CYCLES - 1);

   logic [WRITE_CNT_W-1:0] cnt_q; // cycles spent in the current write

   ////////////////////////////////////////////////////////////////////////////
   // runs off power-on reset so a system reset cannot cut a write short
   always_ff @(posedge clock or posedge por_rst) begin
      if (por_rst) begin
         busy <= 1'b0;
         done <= 1'b0;
         cnt_q <= '0;
      end else begin
         done <= 1'b0;
         if (!busy && start) begin
            busy <= 1'b1;
            cnt_q <= '0;
         end else if (busy && cnt_q == LAST) begin
            busy <= 1'b0;
            done <= 1'b1;
         end else if (busy) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule : spl_nv_timer

// ===== rtl/spl_device.sv
//////////////////////////////////////////////////////////////////////////////
// Function
// - host sets lock via pattern, store within four
// - only boot lock bits can change
// - zero data bits 5..2 program lock bits
// - pointer ignored during lock write
// - host drives data bits 7,6,1,0 high
// - flash stays readable, fetch never blocked
// - eeprom write refuses programming and nv reads
// - host polls eeprom busy before control write
// - lock read at pointer 0001 within three
// - enable bits auto-clear on completion or timeout
// - disarmed load returns ordinary flash byte
// - pointer 0000 returns low fuse byte
// - pointer 0003 returns high fuse byte
// - programmed reads zero, unprogrammed reads one
// - write completes across a system reset
// - write time 3.7 to 4.5 ms
// - interrupt high while enable bit clear
//
// The plain strobed port and the register offsets are this design's own decisions.
module spl_device
   import spl_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = WRITE_MIN_CYC
) (
   // clock and resets
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic por_rst,
   // cpu link
   spl_if.dev_mp cpu,
   // eeprom and nonvolatile sources
   input wire logic eeprom_busy_in,
   input wire logic [7:0] fuse_low_in,
   input wire logic [7:0] fuse_high_in,
   input wire logic [7:0] lock_init_in,
   // program flash read port
   output logic [15:0] flash_addr,
   input wire logic [7:0] flash_data,
   // status
   output logic [7:0] lock_bits,
   output logic nv_busy,
   output logic fetch_hold
);
   //////////////////////////////////////////////////////////////////////////////
   // state
   logic armed_q; // lock select and enable, always set and cleared together
   logic writing_q; // a lock write is under way
   logic [2:0] win_cnt_q; // cycles since the control write
   logic rd_pend_q; // a load answer is due next cycle
   logic rd_nv_q; // the pending load reads a nonvolatile byte
   logic [1:0] rd_sel_q; // pointer bits that select the byte
   logic load_valid_q;
   logic [7:0] load_data_q;
   logic eeprom_busy_q;
   logic spm_irq_q;
   logic lock_loaded_q; // lock byte has been taken from the array
   logic [7:0] pat_q; // lock pattern latched at the store
   logic timer_busy;
   logic timer_done;

   //////////////////////////////////////////////////////////////////////////////
   // decode
   logic cmd_ok;
   logic arm;
   logic open_win;
   logic load_hit;
   logic store_hit;
   logic win_out;
   logic [7:0] nv_byte;

   // only the lock select pattern is handled here
   assign cmd_ok = cpu.ctrl_wdata[6:0] == CTRL_LOCK_CMD;
   // refused while eeprom busy or an operation is still live
   assign arm = cpu.ctrl_wr && cmd_ok && !eeprom_busy_in && !armed_q && !timer_busy;
   assign open_win = armed_q && !writing_q;
   assign load_hit = open_win && cpu.load_req && win_cnt_q < LOAD_WIN && !eeprom_busy_in;
   assign store_hit = open_win && cpu.store_req && win_cnt_q < STORE_WIN && !eeprom_busy_in;
   // last store slot passed with nothing taken
   assign win_out = open_win && win_cnt_q == STORE_WIN - 3'h1 && !store_hit && !load_hit;

   // byte picked by the pointer, raw cell values: zero means programmed
   always_comb begin
      case (rd_sel_q)
         ZPTR_FUSE_LOW[1:0]: nv_byte = fuse_low_in;
         ZPTR_LOCK[1:0]: nv_byte = lock_bits;
         ZPTR_FUSE_HIGH[1:0]: nv_byte = fuse_high_in;
         default: nv_byte = NV_ERASED;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////////
   // command arm and auto-clear
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         armed_q <= 1'b0;
      end else if (arm) begin
         armed_q <= 1'b1;
      end else if (load_hit || win_out) begin
         armed_q <= 1'b0;
      end else if (writing_q && timer_done) begin
         armed_q <= 1'b0;
      end
   end

   // window counter, frozen once a write is running
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         win_cnt_q <= 3'h0;
      end else if (arm) begin
         win_cnt_q <= 3'h0;
      end else if (open_win) begin
         win_cnt_q <= win_cnt_q + 3'h1;
      end
   end

   // write in progress as seen by software; pointer plays no part
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         writing_q <= 1'b0;
      end else if (store_hit) begin
         writing_q <= 1'b1;
      end else if (timer_done) begin
         writing_q <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // load path: every load gets an answer two cycles later
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rd_pend_q <= 1'b0;
         rd_nv_q <= 1'b0;
         rd_sel_q <= 2'h0;
         flash_addr <= 16'h0000;
      end else begin
         rd_pend_q <= cpu.load_req;
         if (cpu.load_req) begin
            rd_nv_q <= load_hit; // disarmed loads go to flash
            rd_sel_q <= cpu.zptr[1:0];
            flash_addr <= cpu.zptr; // flash read even while writing locks
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         load_valid_q <= 1'b0;
         load_data_q <= 8'h00;
      end else begin
         load_valid_q <= rd_pend_q;
         if (rd_pend_q) begin
            load_data_q <= rd_nv_q ? nv_byte : flash_data;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // status back to the cpu
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         eeprom_busy_q <= 1'b0;
         spm_irq_q <= 1'b0;
         fetch_hold <= 1'b0;
      end else begin
         eeprom_busy_q <= eeprom_busy_in;
         // level, not a pulse: software may wait on it instead of polling
         spm_irq_q <= cpu.irq_en && !(arm || (armed_q && !(load_hit || win_out || (writing_q && timer_done))));
         fetch_hold <= 1'b0; // lock writes never stall fetch
      end
   end

   assign cpu.ctrl_rdata = {4'h0, armed_q, 2'b00, armed_q};
   assign cpu.load_valid = load_valid_q;
   assign cpu.load_data = load_data_q;
   assign cpu.eeprom_busy = eeprom_busy_q;
   assign cpu.spm_irq = spm_irq_q;

   //////////////////////////////////////////////////////////////////////////////
   // nonvolatile lock byte, on power-on reset so system reset keeps it
   always_ff @(posedge clock or posedge por_rst) begin
      if (por_rst) begin
         lock_loaded_q <= 1'b0;
         lock_bits <= NV_ERASED;
         pat_q <= NV_ERASED;
      end else begin
         if (store_hit) begin
            pat_q <= cpu.r0_data;
         end
         if (!lock_loaded_q) begin
            // array contents taken after power-on release
            lock_loaded_q <= 1'b1;
            lock_bits <= lock_init_in;
         end else if (timer_done) begin
            // zero pattern bits program, other lock bits untouched
            lock_bits <= lock_bits & (pat_q | ~BOOT_LOCK_MASK);
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // write timer, counted from the internal oscillator clock
   spl_nv_timer #(
      .WRITE_CYCLES(WRITE_CYCLES)
   ) u_timer (
      .clock(clock),
      .por_rst(por_rst),
      .start(store_hit),
      .busy(timer_busy),
      .done(timer_done)
   );

   assign nv_busy = timer_busy;
endmodule : spl_device

// ===== rtl/spl_host.sv
module spl_host
   import spl_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // software register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   // link to the controller
   spl_if.host_mp dev
);
   //////////////////////////////////////////////////////////////////////////////
   // state
   spl_state_e state_q;
   logic op_write_q; // current operation is a lock write
   logic [15:0] zptr_q;
   logic [7:0] data_q;
   logic [7:0] result_q;
   logic [2:0] int_stat_q;
   logic [2:0] int_mask_q;
   logic irq_en_q;
   logic ctrl_wr_q;
   logic store_q;
   logic load_q;
   logic [2:0] ev; // one-cycle events
   logic [2:0] int_stat_d;

   logic cmd_wr;
   assign cmd_wr = reg_wr && reg_addr == HREG_CMD && state_q == SPL_IDLE;

   //////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= SPL_IDLE;
         op_write_q <= 1'b0;
         ctrl_wr_q <= 1'b0;
         store_q <= 1'b0;
         load_q <= 1'b0;
         result_q <= 8'h00;
      end else begin
         ctrl_wr_q <= 1'b0;
         store_q <= 1'b0;
         load_q <= 1'b0;
         case (state_q)
            SPL_IDLE: begin
               if (cmd_wr && (reg_wdata[CMD_WRITE_BIT] || reg_wdata[CMD_READ_BIT])) begin
                  op_write_q <= reg_wdata[CMD_WRITE_BIT];
                  state_q <= SPL_POLL;
               end
            end
            SPL_POLL: begin
               // wait out eeprom writes and any earlier operation
               if (!dev.eeprom_busy && !dev.ctrl_rdata[CTRL_ENABLE_BIT]) begin
                  ctrl_wr_q <= 1'b1;
                  state_q <= SPL_CTRL;
               end
            end
            SPL_CTRL: begin
               state_q <= SPL_ISSUE;
            end
            SPL_ISSUE: begin
               // issued one cycle after readback, well inside the window
               if (dev.ctrl_rdata[CTRL_ENABLE_BIT]) begin
                  store_q <= op_write_q;
                  load_q <= !op_write_q;
                  state_q <= SPL_WAIT;
               end else begin
                  state_q <= SPL_IDLE;
               end
            end
            SPL_WAIT: begin
               if (!op_write_q && dev.load_valid) begin
                  result_q <= dev.load_data;
                  state_q <= SPL_IDLE;
               end else if (op_write_q && !store_q && !dev.ctrl_rdata[CTRL_ENABLE_BIT]) begin
                  state_q <= SPL_IDLE;
               end
            end
            default: state_q <= SPL_IDLE;
         endcase
      end
   end

   assign ev[INT_READ_DONE] = state_q == SPL_WAIT && !op_write_q && dev.load_valid;
   assign ev[INT_WRITE_DONE] = state_q == SPL_WAIT && op_write_q && !store_q && !dev.ctrl_rdata[CTRL_ENABLE_BIT];
   assign ev[INT_REFUSED] = state_q == SPL_ISSUE && !dev.ctrl_rdata[CTRL_ENABLE_BIT];

   //////////////////////////////////////////////////////////////////////////////
   // software registers; a read of the interrupt status clears it, new events win
   assign int_stat_d = ((reg_rd && reg_addr == HREG_INT_STAT) ? 3'h0 : int_stat_q) | ev;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         zptr_q <= HOST_RST_ZPTR;
         data_q <= HOST_RST_DATA;
         int_mask_q <= 3'h0;
         irq_en_q <= 1'b0;
         int_stat_q <= 3'h0;
         irq <= 1'b0;
      end else begin
         int_stat_q <= int_stat_d;
         irq <= |(int_stat_d & int_mask_q);
         if (reg_wr) begin
            case (reg_addr)
               HREG_ZPTR_LO: zptr_q[7:0] <= reg_wdata;
               HREG_ZPTR_HI: zptr_q[15:8] <= reg_wdata;
               HREG_DATA: data_q <= reg_wdata;
               HREG_INT_MASK: int_mask_q <= reg_wdata[2:0];
               HREG_CMD: irq_en_q <= reg_wdata[CMD_IRQ_EN_BIT];
               default: ;
            endcase
         end
      end
   end

   // read data only in the cycle after the strobe
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            HREG_CMD: reg_rdata <= {5'h0, irq_en_q, 2'b00};
            HREG_ZPTR_LO: reg_rdata <= zptr_q[7:0];
            HREG_ZPTR_HI: reg_rdata <= zptr_q[15:8];
            HREG_DATA: reg_rdata <= data_q;
            HREG_RESULT: reg_rdata <= result_q;
            HREG_STATUS: reg_rdata <= {4'h0, dev.spm_irq, dev.eeprom_busy, dev.ctrl_rdata[0], state_q != SPL_IDLE};
            HREG_INT_STAT: reg_rdata <= {5'h0, int_stat_q};
            default: reg_rdata <= {5'h0, int_mask_q};
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // link drive
   assign dev.ctrl_wr = ctrl_wr_q;
   assign dev.ctrl_wdata = CTRL_LOCK_BYTE;
   assign dev.store_req = store_q;
   assign dev.load_req = load_q;
   assign dev.zptr = zptr_q; // software should keep 0001 for lock access
   assign dev.r0_data = data_q | R0_FILL_MASK;
   assign dev.irq_en = irq_en_q;
endmodule : spl_host

// ===== verification/spl_properties.sv
module spl_properties
   import spl_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // link requests
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   input wire logic store_req,
   input wire logic load_req,
   input wire logic [15:0] zptr,
   input wire logic [7:0] r0_data,
   input wire logic irq_en,
   // link answers
   input wire logic [7:0] ctrl_rdata,
   input wire logic load_valid,
   input wire logic [7:0] load_data,
   input wire logic eeprom_busy,
   input wire logic spm_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // every property below lives in the one clock domain
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////
   property p_ctrl_pattern;
      ctrl_wr |-> ctrl_wdata == CTRL_LOCK_BYTE;
   endproperty
   a_ctrl_pattern: assert property (p_ctrl_pattern) else $error("control write with wrong pattern");
   property p_arm_cmd;
      $rose(ctrl_rdata[0]) |-> $past(ctrl_wr) && $past(ctrl_wdata[6:0]) == CTRL_LOCK_CMD;
   endproperty
   a_arm_cmd: assert property (p_arm_cmd) else $error("armed without lock pattern write");
   property p_req_armed;
      (store_req || load_req) |-> ctrl_rdata[0];
   endproperty
   a_req_armed: assert property (p_req_armed) else $error("request issued outside the window");
   property p_code;
      ctrl_rdata == 8'h00 || ctrl_rdata == CTRL_LOCK_BYTE;
   endproperty
   a_code: assert property (p_code) else $error("select and enable bits disagree");
   property p_r0_fill;
      store_req |-> (r0_data & R0_FILL_MASK) == R0_FILL_MASK;
   endproperty
   a_r0_fill: assert property (p_r0_fill) else $error("data bits 7 6 1 0 not high");
   property p_load_answer;
      load_req |-> ##2 load_valid;
   endproperty
   a_load_answer: assert property (p_load_answer) else $error("load not answered");
   property p_valid_cause;
      load_valid |-> $past(load_req, 2);
   endproperty
   a_valid_cause: assert property (p_valid_cause) else $error("answer without load");
   property p_load_clears;
      load_req && ctrl_rdata[0] && !eeprom_busy |=> ctrl_rdata == 8'h00;
   endproperty
   a_load_clears: assert property (p_load_clears) else $error("enable kept after read");
   // a refused store (eeprom busy) counts as no store at all
   property p_arm_timeout;
      $rose(ctrl_rdata[0]) ##0 (!load_req && !(store_req && !eeprom_busy))[*4] |=> !ctrl_rdata[0];
   endproperty
   a_arm_timeout: assert property (p_arm_timeout) else $error("window did not expire");
   property p_store_holds;
      store_req && !eeprom_busy |=> ctrl_rdata[0] [*6];
   endproperty
   a_store_holds: assert property (p_store_holds) else $error("enable dropped during write");
   property p_write_ends;
      store_req |-> ##[2:40] !ctrl_rdata[0];
   endproperty
   a_write_ends: assert property (p_write_ends) else $error("write never finished");
   property p_spm_irq;
      1'b1 |=> spm_irq == ($past(irq_en) && !ctrl_rdata[0]);
   endproperty
   a_spm_irq: assert property (p_spm_irq) else $error("interrupt not tracking enable bit");
endmodule : spl_properties

// ===== verification/self_prog_lock_fuse_access_bench.sv
module self_prog_lock_fuse_access_bench;
   import spl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned WCYC = 8; // short write so the run stays brief
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic por_rst = 1'b1;
   logic eeprom_busy_in = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata, flash_data, lock_bits, rd;
   logic [15:0] flash_addr;
   logic irq, nv_busy, fetch_hold, hold_seen;
   logic [7:0] fuse_low_in = 8'h9d; // arbitrary cell contents
   logic [7:0] fuse_high_in = 8'hd9;
   logic [7:0] lock_init_in = 8'hfe; // one memory lock programmed
   int error_cnt = 0;
   int compares = 0;
   int cnt;
   // flash content is a simple function of its address
   assign flash_data = flash_addr[7:0] ^ 8'h5a;
   always #20 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////
   spl_if spl_if_inst ();
   spl_device #(.WRITE_CYCLES(WCYC)) spl_device_inst (.clock(clock), .sys_rst(sys_rst), .por_rst(por_rst),
      .cpu(spl_if_inst), .eeprom_busy_in(eeprom_busy_in), .fuse_low_in(fuse_low_in), .fuse_high_in(fuse_high_in),
      .lock_init_in(lock_init_in), .flash_addr(flash_addr), .flash_data(flash_data), .lock_bits(lock_bits),
      .nv_busy(nv_busy), .fetch_hold(fetch_hold));
   spl_host spl_host_inst (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .dev(spl_if_inst));
   spl_properties spl_properties_inst (.clock(clock), .sys_rst(sys_rst), .ctrl_wr(spl_if_inst.ctrl_wr),
      .ctrl_wdata(spl_if_inst.ctrl_wdata), .store_req(spl_if_inst.store_req), .load_req(spl_if_inst.load_req),
      .zptr(spl_if_inst.zptr), .r0_data(spl_if_inst.r0_data), .irq_en(spl_if_inst.irq_en),
      .ctrl_rdata(spl_if_inst.ctrl_rdata), .load_valid(spl_if_inst.load_valid),
      .load_data(spl_if_inst.load_data), .eeprom_busy(spl_if_inst.eeprom_busy), .spm_irq(spl_if_inst.spm_irq));
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check8
   // one-cycle write strobe, taken at the second edge
   task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : reg_write
   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_read
   // bounded wait for a level; running out ends the run
   task automatic wait_level(ref logic s, input logic v, input int lim);
      int n;
      n = 0;
      #1;
      while (s !== v) begin
         @(posedge clock);
         #1;
         n++;
         if (n > lim) begin
            error_cnt++;
            $display("Error wait expected %b seen %b", v, s);
            tally_and_finish();
         end
      end
   endtask : wait_level
   // full nonvolatile read through the host sequencer
   task automatic nv_read(input logic [15:0] ptr, input logic [7:0] exp);
      reg_write(HREG_ZPTR_LO, ptr[7:0]);
      reg_write(HREG_ZPTR_HI, ptr[15:8]);
      reg_write(HREG_INT_MASK, 8'h01);
      reg_write(HREG_CMD, 8'h06);
      wait_level(irq, 1'b1, 60);
      reg_read(HREG_INT_STAT, rd);
      check8("int_stat_read", 8'h01, rd);
      reg_read(HREG_RESULT, rd);
      check8("nv_result", exp, rd);
      check8("irq_cleared", 8'h00, {7'h0, irq});
   endtask : nv_read
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clock);
      por_rst <= 1'b0;
      sys_rst <= 1'b0;
      repeat (2) @(posedge clock);
      // reset values of the host registers and the lock byte
      reg_read(HREG_ZPTR_LO, rd);
      check8("zptr_lo", 8'h01, rd);
      reg_read(HREG_DATA, rd);
      check8("data", 8'hff, rd);
      reg_read(HREG_STATUS, rd);
      check8("status", 8'h00, rd);
      check8("lock_bits", 8'hfe, lock_bits);
      $display("test reset done");
      // interrupt line with the enable bit clear
      reg_write(HREG_CMD, 8'h04);
      repeat (3) @(posedge clock);
      reg_read(HREG_STATUS, rd);
      check8("status_irq", 8'h08, rd);
      nv_read(ZPTR_LOCK, 8'hfe);
      nv_read(ZPTR_FUSE_LOW, fuse_low_in);
      nv_read(ZPTR_FUSE_HIGH, fuse_high_in);
      nv_read(16'h0002, 8'hff);
      $display("test reads done");
      // lock write with a stray pointer and low filler bits
      reg_write(HREG_DATA, 8'h28);
      reg_write(HREG_INT_MASK, 8'h02);
      reg_write(HREG_CMD, 8'h05);
      wait_level(nv_busy, 1'b1, 20);
      cnt = 0;
      hold_seen = 1'b0;
      while (nv_busy === 1'b1 && cnt < 200) begin
         if (fetch_hold !== 1'b0) hold_seen = 1'b1;
         @(posedge clock);
         #1;
         cnt++;
      end
      check8("write_time", 8'h01, {7'h0, cnt >= WCYC && cnt <= WCYC + 2});
      check8("fetch_hold", 8'h00, {7'h0, hold_seen});
      wait_level(irq, 1'b1, 20);
      reg_read(HREG_INT_STAT, rd);
      check8("int_stat_write", 8'h02, rd);
      check8("lock_after_write", 8'hea, lock_bits);
      nv_read(ZPTR_LOCK, 8'hea);
      $display("test lock write done");
      // eeprom write begins inside the window: store refused, window lapses
      reg_write(HREG_DATA, 8'h00);
      reg_write(HREG_CMD, 8'h05);
      @(posedge clock);
      @(posedge clock);
      eeprom_busy_in <= 1'b1;
      repeat (20) @(posedge clock);
      eeprom_busy_in <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      check8("lock_refused", 8'hea, lock_bits);
      reg_read(HREG_INT_STAT, rd);
      check8("int_stat_refused", 8'h02, rd);
      $display("test refusal done");
      // system reset in mid write, the write still lands
      reg_write(HREG_CMD, 8'h05);
      wait_level(nv_busy, 1'b1, 20);
      repeat (3) @(posedge clock);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      wait_level(nv_busy, 1'b0, 40);
      @(posedge clock);
      #1;
      check8("lock_after_reset", 8'hc2, lock_bits);
      $display("test reset write done");
      // read held off while the eeprom writes
      @(posedge clock);
      eeprom_busy_in <= 1'b1;
      reg_write(HREG_INT_MASK, 8'h01);
      reg_write(HREG_CMD, 8'h06);
      repeat (10) @(posedge clock);
      reg_read(HREG_STATUS, rd);
      check8("status_eeprom", 8'h0d, rd);
      reg_read(HREG_INT_STAT, rd);
      check8("no_read_yet", 8'h00, rd);
      @(posedge clock);
      eeprom_busy_in <= 1'b0;
      wait_level(irq, 1'b1, 60);
      reg_read(HREG_RESULT, rd);
      check8("lock_late_read", 8'hc2, rd);
      $display("test eeprom busy done");
      tally_and_finish();
   end
endmodule : self_prog_lock_fuse_access_bench
